//--- verilog/ulf_pkg.sv
// Constants for the UART interrupt ranking and line format block.
package ulf_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte addresses.
  localparam logic [7:0] OFS_INT_ENABLE = 8'h00;
  localparam logic [7:0] OFS_IDENT = 8'h04;
  localparam logic [7:0] OFS_FIFO_SETUP = 8'h08;
  localparam logic [7:0] OFS_LINE_FORMAT = 8'h0C;
  localparam logic [7:0] OFS_DIV_LOW = 8'h10;
  localparam logic [7:0] OFS_DIV_HIGH = 8'h14;
  localparam logic [7:0] OFS_FEATURE = 8'h18;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions.
  localparam int LF_DIV_ACCESS = 7;
  localparam int LF_BREAK = 6;
  localparam int LF_PAR_FORCE = 5;
  localparam int LF_PAR_EVEN = 4;
  localparam int LF_PAR_EN = 3;
  localparam int LF_STOP = 2;
  localparam int FS_ENABLE = 0;
  localparam int FS_RX_CLEAR = 1;
  localparam int FS_TX_CLEAR = 2;
  localparam int IE_RX_DATA = 0;
  localparam int IE_TX_EMPTY = 1;
  localparam int IE_LINE = 2;
  localparam int IE_MODEM = 3;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values.
  localparam logic [7:0] RST_LINE_FORMAT = 8'h00;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [3:0] RST_INT_ENABLE = 4'h0;
  localparam logic [1:0] RST_TRIGGER = 2'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Receive trigger levels in bytes.
  localparam logic [4:0] TRIG_LVL_0 = 5'h01;
  localparam logic [4:0] TRIG_LVL_1 = 5'h04;
  localparam logic [4:0] TRIG_LVL_2 = 5'h08;
  localparam logic [4:0] TRIG_LVL_3 = 5'h0E;

  ////////////////////////////////////////////////////////////////////////////
  // Identification codes, bits 3:0.
  localparam logic [3:0] ID_NONE = 4'h1;
  localparam logic [3:0] ID_LINE = 4'h6;
  localparam logic [3:0] ID_RX_DATA = 4'h4;
  localparam logic [3:0] ID_TIMEOUT = 4'hC;
  localparam logic [3:0] ID_TX_EMPTY = 4'h2;
  localparam logic [3:0] ID_MODEM = 4'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Character and stop widths; stop length in half bit times.
  localparam logic [3:0] CHAR_BITS_BASE = 4'h5;
  localparam logic [2:0] STOP_ONE = 3'h2;
  localparam logic [2:0] STOP_ONE_HALF = 3'h3;
  localparam logic [2:0] STOP_TWO = 3'h4;

  // Interrupt sources, Gray coded in priority order.
  typedef enum logic [2:0] {
    ULF_SRC_NONE = 3'b000,
    ULF_SRC_LINE = 3'b001,
    ULF_SRC_RX_DATA = 3'b011,
    ULF_SRC_TIMEOUT = 3'b010,
    ULF_SRC_TX_EMPTY = 3'b110,
    ULF_SRC_MODEM = 3'b111
  } ulf_src_t;

endpackage : ulf_pkg

//--- verilog/ulf_rank.sv
// Priority ranking of the gated interrupt sources.
`timescale 1ns/10ps
`default_nettype none

module ulf_rank (
  input wire logic [4:0] pend,          // Gated pending: line, data, timeout, empty, modem.
  output var ulf_pkg::ulf_src_t top_src // Highest pending source.
);

  wire logic [4:0] first_hot;
  wire logic [4:0] blocked;

  // Each bit is blocked by any higher-ranked pending bit.
  genvar g;
  generate
    for (g = 0; g < 5; g++) begin : g_rank
      if (g == 0) begin : g_top
        assign blocked[g] = 1'b0;
      end else begin : g_rest
        assign blocked[g] = |pend[g-1:0];
      end
      assign first_hot[g] = pend[g] & ~blocked[g];
    end
  endgenerate

  assign top_src = first_hot[0] ? ulf_pkg::ULF_SRC_LINE :
                   first_hot[1] ? ulf_pkg::ULF_SRC_RX_DATA :
                   first_hot[2] ? ulf_pkg::ULF_SRC_TIMEOUT :
                   first_hot[3] ? ulf_pkg::ULF_SRC_TX_EMPTY :
                   first_hot[4] ? ulf_pkg::ULF_SRC_MODEM :
                   ulf_pkg::ULF_SRC_NONE;

endmodule : ulf_rank

`default_nettype wire

//--- verilog/ulf_core.sv
// APB register block for interrupt ranking, FIFO setup and line format.
`timescale 1ns/10ps
`default_nettype none

module ulf_core (
  input wire logic pclk,                    // Bus clock, 50 MHz.
  input wire logic presetn,                 // Asynchronous reset, active low.
  input wire logic psel,                    // APB select.
  input wire logic penable,                 // APB access phase.
  input wire logic pwrite,                  // APB write when high.
  input wire logic [7:0] paddr,             // APB byte address.
  input wire logic [31:0] pwdata,           // APB write data.
  output logic [31:0] prdata,               // APB read data.
  output logic pready,                      // APB ready.
  output logic pslverr,                     // APB error for unmapped access or identification write.
  input wire logic [4:0] rx_fifo_count,     // Receive FIFO occupancy.
  input wire logic line_status_event,       // Receiver line condition pulse.
  input wire logic rx_timeout_event,        // Receive time-out pulse.
  input wire logic tx_empty_event,          // Holding register became empty.
  input wire logic modem_change_event,      // Modem change condition pulse.
  input wire logic tx_serial_raw,           // Serial output of the shifter.
  output logic tx_pin,                      // Serial output to the line.
  input wire logic [7:0] tx_char,           // Character being sent.
  output logic tx_parity_bit,               // Parity bit to append.
  input wire logic [7:0] rx_char,           // Character received.
  input wire logic rx_parity_in,            // Parity bit received.
  output logic rx_parity_error,             // Received parity mismatch.
  output logic [3:0] char_bits,             // Character length, 5 to 8.
  output logic [2:0] stop_half_bits,        // Stop length in half bits.
  output logic parity_enable,               // Parity bit in use.
  output logic break_active,                // Break being sent.
  output logic divisor_access,              // Divisor registers reachable.
  output logic [15:0] divisor,              // Baud divisor.
  output logic [7:0] enhanced_feature,      // Enhanced feature register.
  output logic fifo_enable,                 // FIFOs switched on.
  output logic [4:0] rx_trigger_level,      // Receive trigger in bytes.
  output logic rx_fifo_clear,               // One-cycle receive FIFO clear.
  output logic tx_fifo_clear                // One-cycle transmit FIFO clear.
);

  ////////////////////////////////////////////////////////////////////////////
  // Register storage.
  logic [7:0] line_format_control;
  logic [3:0] int_enable;
  logic [1:0] rx_trigger_sel;
  logic [7:0] div_low;
  logic [7:0] div_high;
  logic line_pend;
  logic timeout_pend;
  logic tx_empty_pend;
  logic modem_pend;
  ulf_pkg::ulf_src_t cur_src;
  ulf_pkg::ulf_src_t top_src;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode. The first access cycle captures read data, the second ends.
  // Every access takes exactly one wait state, so a read-clear never acts
  // before its data has been captured.
  wire logic access_first = psel & penable & ~pready;
  wire logic access_done = psel & penable & pready;
  wire logic wr_done = access_done & pwrite;
  wire logic rd_done = access_done & ~pwrite;
  wire logic hit_ie = (paddr == ulf_pkg::OFS_INT_ENABLE);
  wire logic hit_id = (paddr == ulf_pkg::OFS_IDENT);
  wire logic hit_fs = (paddr == ulf_pkg::OFS_FIFO_SETUP);
  wire logic hit_lf = (paddr == ulf_pkg::OFS_LINE_FORMAT);
  wire logic dl_open = line_format_control[ulf_pkg::LF_DIV_ACCESS];
  wire logic hit_dl = dl_open & (paddr == ulf_pkg::OFS_DIV_LOW);
  wire logic hit_dh = dl_open & (paddr == ulf_pkg::OFS_DIV_HIGH);
  wire logic hit_ef = dl_open & (paddr == ulf_pkg::OFS_FEATURE);
  wire logic mapped = hit_ie | hit_id | hit_fs | hit_lf | hit_dl | hit_dh | hit_ef;
  wire logic id_ro_write = hit_id & pwrite;
  wire logic bad_access = ~mapped | id_ro_write;
  wire logic id_read_done = rd_done & hit_id;

  // Errors go out with ready: unmapped offsets, closed divisor offsets and
  // writes to the identification register.
  assign pslverr = pready & bad_access;

  // Ready rises for the second access cycle only, so an access that is
  // already ending cannot start another wait state.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= access_first;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Line format register and its decoded fields.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_format_control <= ulf_pkg::RST_LINE_FORMAT;
    end else if (wr_done && hit_lf) begin
      line_format_control <= pwdata[7:0];
    end
  end

  wire logic par_en = line_format_control[ulf_pkg::LF_PAR_EN];
  wire logic par_force = line_format_control[ulf_pkg::LF_PAR_FORCE];
  wire logic par_even = line_format_control[ulf_pkg::LF_PAR_EVEN];
  wire logic [1:0] len_sel = line_format_control[1:0];
  wire logic is_five = (len_sel == 2'b00);
  wire logic long_stop = line_format_control[ulf_pkg::LF_STOP];
  wire logic [3:0] next_char_bits = ulf_pkg::CHAR_BITS_BASE + {2'b00, len_sel};
  wire logic [2:0] next_stop = !long_stop ? ulf_pkg::STOP_ONE :
                               is_five ? ulf_pkg::STOP_ONE_HALF : ulf_pkg::STOP_TWO;

  // Only the character's used bits enter the parity sum.
  wire logic [7:0] len_mask = 8'hFF >> (2'd3 - len_sel);
  wire logic tx_ones_odd = ^(tx_char & len_mask);
  wire logic rx_ones_odd = ^(rx_char & len_mask);
  // Odd parity makes the total count of ones odd; forced modes ignore data.
  wire logic next_tx_par = par_force ? ~par_even : (par_even ? tx_ones_odd : ~tx_ones_odd);
  wire logic next_rx_expect = par_force ? ~par_even :
                              (par_even ? rx_ones_odd : ~rx_ones_odd);
  wire logic next_rx_perr = par_en & (rx_parity_in != next_rx_expect);

  // Format outputs are registered copies, so a new format takes effect one
  // cycle after the write completes.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      char_bits <= ulf_pkg::CHAR_BITS_BASE;
      stop_half_bits <= ulf_pkg::STOP_ONE;
      parity_enable <= 1'b0;
      break_active <= 1'b0;
      divisor_access <= 1'b0;
    end else begin
      char_bits <= next_char_bits;
      stop_half_bits <= next_stop;
      parity_enable <= par_en;
      break_active <= line_format_control[ulf_pkg::LF_BREAK];
      divisor_access <= dl_open;
    end
  end

  // Break forces the line low for as long as the bit stays set.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_pin <= 1'b1;
      tx_parity_bit <= 1'b0;
      rx_parity_error <= 1'b0;
    end else begin
      tx_pin <= tx_serial_raw & ~line_format_control[ulf_pkg::LF_BREAK];
      tx_parity_bit <= par_en & next_tx_par;
      rx_parity_error <= next_rx_perr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Divisor latch and enhanced feature register, reachable only when open.
  // A closed latch refuses the access with an error and keeps its contents.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_low <= ulf_pkg::RST_BYTE;
      div_high <= ulf_pkg::RST_BYTE;
      enhanced_feature <= ulf_pkg::RST_BYTE;
    end else begin
      if (wr_done && hit_dl) begin
        div_low <= pwdata[7:0];
      end
      if (wr_done && hit_dh) begin
        div_high <= pwdata[7:0];
      end
      if (wr_done && hit_ef) begin
        enhanced_feature <= pwdata[7:0];
      end
    end
  end

  assign divisor = {div_high, div_low};

  ////////////////////////////////////////////////////////////////////////////
  // FIFO setup. Trigger bits change only when the write keeps the enable set.
  // The clear pulses last one cycle; the FIFO storage outside acts on them.
  wire logic fs_write = wr_done & hit_fs;
  wire logic fs_keep = pwdata[ulf_pkg::FS_ENABLE];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fifo_enable <= 1'b0;
      rx_trigger_sel <= ulf_pkg::RST_TRIGGER;
      rx_fifo_clear <= 1'b0;
      tx_fifo_clear <= 1'b0;
    end else begin
      rx_fifo_clear <= fs_write & fs_keep & pwdata[ulf_pkg::FS_RX_CLEAR];
      tx_fifo_clear <= fs_write & fs_keep & pwdata[ulf_pkg::FS_TX_CLEAR];
      if (fs_write) begin
        fifo_enable <= fs_keep;
      end
      if (fs_write && fs_keep) begin
        rx_trigger_sel <= pwdata[7:6];
      end
    end
  end

  // Only the four trigger levels can come out of this table.
  always_comb begin
    case (rx_trigger_sel)
      2'b00: rx_trigger_level = ulf_pkg::TRIG_LVL_0;
      2'b01: rx_trigger_level = ulf_pkg::TRIG_LVL_1;
      2'b10: rx_trigger_level = ulf_pkg::TRIG_LVL_2;
      2'b11: rx_trigger_level = ulf_pkg::TRIG_LVL_3;
      default: rx_trigger_level = ulf_pkg::TRIG_LVL_0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt enables. The time-out shares the data enable, as both belong
  // to the receive side.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_enable <= ulf_pkg::RST_INT_ENABLE;
    end else if (wr_done && hit_ie) begin
      int_enable <= pwdata[3:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky event sources, ordered line, time-out, empty, modem. A read clears
  // only the one in cur_src at its clearing edge, which can be one loaded after
  // a capture that read as none; an event in the clearing cycle sets the flag again.
  wire logic [3:0] src_event = {modem_change_event, tx_empty_event, rx_timeout_event,
                                line_status_event};
  wire logic [3:0] src_clear;
  wire logic [3:0] sticky_pend;

  assign src_clear[0] = id_read_done & (cur_src == ulf_pkg::ULF_SRC_LINE);
  assign src_clear[1] = id_read_done & (cur_src == ulf_pkg::ULF_SRC_TIMEOUT);
  assign src_clear[2] = id_read_done & (cur_src == ulf_pkg::ULF_SRC_TX_EMPTY);
  assign src_clear[3] = id_read_done & (cur_src == ulf_pkg::ULF_SRC_MODEM);

  genvar s;
  generate
    for (s = 0; s < 4; s++) begin : g_sticky
      logic flag;
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          flag <= 1'b0;
        end else begin
          flag <= src_event[s] | (flag & ~src_clear[s]);
        end
      end
      assign sticky_pend[s] = flag;
    end
  endgenerate

  assign line_pend = sticky_pend[0];
  assign timeout_pend = sticky_pend[1];
  assign tx_empty_pend = sticky_pend[2];
  assign modem_pend = sticky_pend[3];

  // Data available follows occupancy: trigger level in FIFO mode, any byte else.
  // The level is not sticky, so a read cannot clear it.
  wire logic rx_level_hit = fifo_enable ? (rx_fifo_count >= rx_trigger_level)
                                        : (rx_fifo_count != 5'h00);

  wire logic [4:0] gated_pend;
  assign gated_pend[0] = line_pend & int_enable[ulf_pkg::IE_LINE];
  assign gated_pend[1] = rx_level_hit & int_enable[ulf_pkg::IE_RX_DATA];
  assign gated_pend[2] = timeout_pend & int_enable[ulf_pkg::IE_RX_DATA];
  assign gated_pend[3] = tx_empty_pend & int_enable[ulf_pkg::IE_TX_EMPTY];
  assign gated_pend[4] = modem_pend & int_enable[ulf_pkg::IE_MODEM];

  // The ranking is purely combinational; its result is taken one edge later.
  ulf_rank u_rank (
    .pend(gated_pend),
    .top_src(top_src)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Reported source. It is held until serviced or withdrawn, then reloaded.
  // Holding it keeps a newer, higher event from changing the code between
  // the capture and the clearing edge of one read.
  logic cur_alive;

  always_comb begin
    case (cur_src)
      ulf_pkg::ULF_SRC_LINE: cur_alive = gated_pend[0];
      ulf_pkg::ULF_SRC_RX_DATA: cur_alive = gated_pend[1];
      ulf_pkg::ULF_SRC_TIMEOUT: cur_alive = gated_pend[2];
      ulf_pkg::ULF_SRC_TX_EMPTY: cur_alive = gated_pend[3];
      ulf_pkg::ULF_SRC_MODEM: cur_alive = gated_pend[4];
      default: cur_alive = 1'b0;
    endcase
  end

  wire logic cur_keep = cur_alive & ~id_read_done;
  wire ulf_pkg::ulf_src_t next_cur_src = cur_keep ? cur_src : top_src;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_src <= ulf_pkg::ULF_SRC_NONE;
    end else begin
      cur_src <= next_cur_src;
    end
  end

  logic [3:0] id_code;

  always_comb begin
    case (cur_src)
      ulf_pkg::ULF_SRC_NONE: id_code = ulf_pkg::ID_NONE;
      ulf_pkg::ULF_SRC_LINE: id_code = ulf_pkg::ID_LINE;
      ulf_pkg::ULF_SRC_RX_DATA: id_code = ulf_pkg::ID_RX_DATA;
      ulf_pkg::ULF_SRC_TIMEOUT: id_code = ulf_pkg::ID_TIMEOUT;
      ulf_pkg::ULF_SRC_TX_EMPTY: id_code = ulf_pkg::ID_TX_EMPTY;
      ulf_pkg::ULF_SRC_MODEM: id_code = ulf_pkg::ID_MODEM;
      default: id_code = ulf_pkg::ID_NONE;
    endcase
  end

  // A source that was withdrawn reads as no interrupt.
  // Bits 7:6 follow the FIFO enable without delay.
  wire logic [3:0] id_live = cur_alive ? id_code : ulf_pkg::ID_NONE;
  wire logic [7:0] id_byte = {{2{fifo_enable}}, 2'b00, id_live};

  ////////////////////////////////////////////////////////////////////////////
  // Read data, captured in the first access cycle.
  // Write cycles and refused reads return zero.
  wire logic [7:0] fs_view = {rx_trigger_sel, 5'b00000, fifo_enable};
  wire logic [7:0] rd_byte = hit_ie ? {4'h0, int_enable} :
                             hit_id ? id_byte :
                             hit_fs ? fs_view :
                             hit_lf ? line_format_control :
                             hit_dl ? div_low :
                             hit_dh ? div_high :
                             hit_ef ? enhanced_feature : 8'h00;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (access_first) begin
      prdata <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
    end
  end

endmodule : ulf_core

`default_nettype wire

//--- verif/ulf_checker.sv
// Port assertions for the interrupt ranking and line format block.
`timescale 1ns/10ps
`default_nettype none
module ulf_checker (
  input wire logic pclk, // Clock.
  input wire logic presetn, // Reset, active low.
  input wire logic psel, // Select.
  input wire logic penable, // Access phase.
  input wire logic pready, // Ready.
  input wire logic pslverr, // Error.
  input wire logic tx_pin, // Serial line.
  input wire logic break_active, // Break flag.
  input wire logic [3:0] char_bits, // Length.
  input wire logic [2:0] stop_half_bits, // Stop length.
  input wire logic parity_enable, // Parity on.
  input wire logic rx_parity_error, // Parity fault.
  input wire logic [4:0] rx_trigger_level, // Trigger.
  input wire logic rx_fifo_clear // Clear pulse.
);
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence acc_s;
    psel && !penable ##1 psel && penable;
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  ready_wait_a: assert property (acc_s |-> !pready ##1 pready)
    else $error("ready not after one wait state");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held too long");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  break_low_a: assert property (break_active && $past(break_active) |-> !tx_pin)
    else $error("line not low in break");
  reset_fmt_a: assert property ($rose(presetn) |-> char_bits == 4'h5 &&
    stop_half_bits == 3'h2 && !parity_enable && !break_active && tx_pin)
    else $error("format not at reset value");
  stop_len_a: assert property (stop_half_bits == 3'h3 |-> char_bits == 4'h5)
    else $error("half stop with long character");
  trig_set_a: assert property (rx_trigger_level inside {5'h01, 5'h04, 5'h08, 5'h0E})
    else $error("bad trigger level");
  par_err_a: assert property (!parity_enable && !$past(parity_enable) |-> !rx_parity_error)
    else $error("parity error with parity off");
  clear_pulse_a: assert property (rx_fifo_clear |=> !rx_fifo_clear)
    else $error("clear pulse too long");
endmodule : ulf_checker
bind ulf_core ulf_checker u_chk (.pclk, .presetn, .psel, .penable, .pready, .pslverr, .tx_pin,
  .break_active, .char_bits, .stop_half_bits, .parity_enable, .rx_parity_error,
  .rx_trigger_level, .rx_fifo_clear);
`default_nettype wire

//--- verif/ulf_host.sv
// Host processor model that masters the register bus.
`timescale 1ns/10ps
`default_nettype none
module ulf_host (
  input wire logic pclk, // Clock.
  output logic psel, // Select.
  output logic penable, // Access phase.
  output logic pwrite, // Direction.
  output logic [7:0] paddr, // Address.
  output logic [31:0] pwdata, // Write data.
  input wire logic pready // Ready.
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
  end
  // Called just after a rising edge; leaves one idle edge so calls can chain.
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : xfer
endmodule : ulf_host
`default_nettype wire

//--- verif/tb_uart_irq_priority_line_format.sv
// Self-checking testbench for the interrupt ranking and line format block.
`timescale 1ns/10ps
`default_nettype none
module tb_uart_irq_priority_line_format;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, pready, pslverr, tx_serial_raw, tx_pin;
  logic line_status_event, rx_timeout_event, tx_empty_event, modem_change_event;
  logic tx_parity_bit, rx_parity_in, rx_parity_error, parity_enable, break_active;
  logic divisor_access, fifo_enable, rx_fifo_clear, tx_fifo_clear;
  logic [7:0] paddr, tx_char, rx_char, enhanced_feature, v;
  logic [31:0] pwdata, prdata, seed;
  logic [4:0] rx_fifo_count, rx_trigger_level;
  logic [3:0] char_bits;
  logic [2:0] stop_half_bits, stp;
  logic [15:0] divisor;
  logic [32:0] exp_q[$];
  logic [4:0] lvl[4] = '{5'h01, 5'h04, 5'h08, 5'h0E};
  int failures = 0;
  int tests_run = 0;
  int rx_clr_n = 0;
  int tx_clr_n = 0;
  always #10 pclk = ~pclk;
  ulf_core u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .rx_fifo_count, .line_status_event, .rx_timeout_event, .tx_empty_event,
    .modem_change_event, .tx_serial_raw, .tx_pin, .tx_char, .tx_parity_bit, .rx_char,
    .rx_parity_in, .rx_parity_error, .char_bits, .stop_half_bits, .parity_enable, .break_active,
    .divisor_access, .divisor, .enhanced_feature, .fifo_enable, .rx_trigger_level,
    .rx_fifo_clear, .tx_fifo_clear);
  ulf_host u_host (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .pready);
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [32:0] g, input logic [32:0] e);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : print_verdict
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic e);
    exp_q.push_back({e, 32'h0000_0000});
    u_host.xfer(1'b1, a, {24'h00_0000, d});
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic e);
    exp_q.push_back({e, 24'h00_0000, d});
    u_host.xfer(1'b0, a, 32'h0000_0000);
  endtask : rd
  task automatic pulse(input logic [3:0] m);
    {line_status_event, rx_timeout_event, tx_empty_event, modem_change_event} <= m;
    @(posedge pclk);
    {line_status_event, rx_timeout_event, tx_empty_event, modem_change_event} <= 4'h0;
    repeat (3) @(posedge pclk);
  endtask : pulse
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  function automatic logic exp_par(input logic [7:0] f, input logic [7:0] c);
    logic p;
    p = ^(c & (8'hFF >> (2'd3 - f[1:0])));
    return f[3] & (f[5] ? ~f[4] : (p ^ ~f[4]));
  endfunction : exp_par
  // Every completed transfer is compared against the oldest note.
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1) chk({pslverr, prdata}, exp_q.pop_front());
    rx_clr_n += int'(rx_fifo_clear);
    tx_clr_n += int'(tx_fifo_clear);
  end
  initial begin
    repeat (20000) @(posedge pclk);
    failures++;
    print_verdict();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    presetn = 1'b0;
    {line_status_event, rx_timeout_event, tx_empty_event, modem_change_event} = 4'h0;
    rx_fifo_count = 5'h00;
    tx_serial_raw = 1'b1;
    tx_char = 8'h00;
    rx_char = 8'h00;
    rx_parity_in = 1'b0;
    seed = 32'h0000_003F;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(ulf_pkg::OFS_LINE_FORMAT, 8'h00, 1'b0);
    rd(ulf_pkg::OFS_IDENT, 8'h01, 1'b0);
    wr(ulf_pkg::OFS_INT_ENABLE, 8'h0F, 1'b0);
    pulse(4'b1011);
    rd(ulf_pkg::OFS_IDENT, 8'h06, 1'b0);
    rd(ulf_pkg::OFS_IDENT, 8'h02, 1'b0);
    rd(ulf_pkg::OFS_IDENT, 8'h00, 1'b0);
    rd(ulf_pkg::OFS_IDENT, 8'h01, 1'b0);
    wr(ulf_pkg::OFS_INT_ENABLE, 8'h00, 1'b0);
    pulse(4'b0001);
    rd(ulf_pkg::OFS_IDENT, 8'h01, 1'b0);
    wr(ulf_pkg::OFS_INT_ENABLE, 8'h08, 1'b0);
    repeat (2) @(posedge pclk);
    rd(ulf_pkg::OFS_IDENT, 8'h00, 1'b0);
    wr(ulf_pkg::OFS_INT_ENABLE, 8'h01, 1'b0);
    for (int t = 0; t < 4; t++) begin
      wr(ulf_pkg::OFS_FIFO_SETUP, {t[1:0], 6'h01}, 1'b0);
      chk(33'(rx_trigger_level), 33'(lvl[t]));
    end
    rd(ulf_pkg::OFS_FIFO_SETUP, 8'hC1, 1'b0);
    rx_fifo_count <= 5'h0D;
    repeat (3) @(posedge pclk);
    rd(ulf_pkg::OFS_IDENT, 8'hC1, 1'b0);
    rx_fifo_count <= 5'h0E;
    repeat (3) @(posedge pclk);
    rd(ulf_pkg::OFS_IDENT, 8'hC4, 1'b0);
    rd(ulf_pkg::OFS_IDENT, 8'hC4, 1'b0);
    rx_fifo_count <= 5'h00;
    pulse(4'b0100);
    rd(ulf_pkg::OFS_IDENT, 8'hCC, 1'b0);
    rd(ulf_pkg::OFS_IDENT, 8'hC1, 1'b0);
    wr(ulf_pkg::OFS_FIFO_SETUP, 8'h07, 1'b0);
    wr(ulf_pkg::OFS_FIFO_SETUP, 8'h00, 1'b0);
    rd(ulf_pkg::OFS_IDENT, 8'h01, 1'b0);
    wr(ulf_pkg::OFS_FIFO_SETUP, 8'h06, 1'b0);
    chk(33'({fifo_enable, rx_clr_n[3:0], tx_clr_n[3:0]}), 33'(9'h011));
    wr(ulf_pkg::OFS_DIV_LOW, 8'h34, 1'b1);
    wr(ulf_pkg::OFS_LINE_FORMAT, 8'h80, 1'b0);
    wr(ulf_pkg::OFS_DIV_LOW, 8'h34, 1'b0);
    wr(ulf_pkg::OFS_DIV_HIGH, 8'h12, 1'b0);
    wr(ulf_pkg::OFS_FEATURE, 8'h5A, 1'b0);
    chk(33'({divisor_access, divisor, enhanced_feature}), 33'(25'h112_345A));
    rd(ulf_pkg::OFS_DIV_LOW, 8'h34, 1'b0);
    rd(8'h1C, 8'h00, 1'b1);
    wr(ulf_pkg::OFS_IDENT, 8'h00, 1'b1);
    for (int i = 0; i < 32; i++) begin
      seed = xs(seed);
      v = {1'b0, seed[6], i[3:2], i[4], seed[2], i[1:0]};
      stp = v[2] ? ((v[1:0] == 2'b00) ? 3'h3 : 3'h4) : 3'h2;
      tx_char <= seed[15:8];
      rx_char <= seed[15:8];
      tx_serial_raw <= seed[16];
      rx_parity_in <= exp_par(v, seed[15:8]) ^ seed[17];
      wr(ulf_pkg::OFS_LINE_FORMAT, v, 1'b0);
      repeat (2) @(posedge pclk);
      chk(33'({char_bits, stop_half_bits}), 33'({4'h5 + 4'(v[1:0]), stp}));
      chk(33'({parity_enable, break_active, tx_pin}), 33'({v[3], v[6], seed[16] & ~v[6]}));
      chk(33'({tx_parity_bit, rx_parity_error}), 33'({exp_par(v, seed[15:8]), v[3] & seed[17]}));
      rd(ulf_pkg::OFS_LINE_FORMAT, v, 1'b0);
    end
    print_verdict();
  end
endmodule : tb_uart_irq_priority_line_format
`default_nettype wire
